// File: src/pio_pin_cell.sv
// One pin of the I/O port: function decode and pad control
`timescale 1ns/1ps

module pio_pin_cell #(
   parameter bit PULL_DOWN = 1'b0
) (
   input  wire logic mode_bit,
   input  wire logic dir_bit,
   input  wire logic value_bit,
   input  wire logic periph_out,
   input  wire logic periph_oe,
   output logic      pin_out,
   output logic      pin_oe,
   output logic      pull_en,
   output logic      pull_up,
   output logic      gp_input
);

   logic normal_fn;
   logic gp_output;

   // Function from mode and direction bits
   always_comb begin
      normal_fn = !mode_bit && !dir_bit;
      gp_output = mode_bit && !dir_bit;
      gp_input  = dir_bit;
   end

   // Pad drive: peripheral on normal function, data bit on output
   always_comb begin
      if (normal_fn) begin
         pin_out = periph_out;
         pin_oe  = periph_oe;
      end else if (gp_output) begin
         pin_out = value_bit;
         pin_oe  = 1'b1;
      end else begin
         pin_out = 1'b0;
         pin_oe  = 1'b0;
      end
   end

   // Pull only on an input with mode bit 0
   always_comb begin
      pull_en = dir_bit && !mode_bit;
      pull_up = !PULL_DOWN;
   end

endmodule // pio_pin_cell

// File: src/pio_pkg.sv
// Shared constants of the programmable I/O port
package pio_pkg;

   // Pin count and register width
   localparam int unsigned PINS   = 32;
   localparam int unsigned HALF   = 16;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned IDX_W  = 10;

   // Register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_MODE_LOW  = 10'h070;
   localparam logic [IDX_W-1:0] IDX_DIR_LOW   = 10'h072;
   localparam logic [IDX_W-1:0] IDX_VALUE_LOW = 10'h074;
   localparam logic [IDX_W-1:0] IDX_MODE_HIGH = 10'h076;
   localparam logic [IDX_W-1:0] IDX_DIR_HIGH  = 10'h078;
   localparam logic [IDX_W-1:0] IDX_VALUE_HIGH = 10'h07a;

   // Byte address bits that carry the index
   localparam int unsigned IDX_LSB = 2;

   // Reset values
   localparam logic [HALF-1:0] MODE_LOW_RST  = 16'h0000;
   localparam logic [HALF-1:0] MODE_HIGH_RST = 16'h0000;
   localparam logic [HALF-1:0] DIR_LOW_RST   = 16'hfc0f;
   localparam logic [HALF-1:0] DIR_HIGH_RST  = 16'hffff;

   // Pins whose pull resistor pulls down (pins 1 and 6)
   localparam logic [PINS-1:0] PULL_DOWN_MASK = 32'h0000_0042;

   // High-half direction bits of pins 26 and 29, cleared by a low strap
   localparam logic [HALF-1:0] STRAP_NORMAL_HIGH = 16'h2400;

   // Upper read data lanes
   localparam logic [HALF-1:0] READ_PAD = 16'h0000;

endpackage : pio_pkg

// File: src/pio_port.sv
// Top of the 32-pin programmable I/O port with APB register access
//
// Operation
// - With mode bit 0, direction 0 keeps the peripheral function and direction 1 gives a pulled input.
// - With mode bit 1, direction 0 gives a general output and direction 1 an input without pull.
// - A general output drives the pin with its bit of the data register.
// - A general input loads the sampled pin level into its bit of the data register.
// - Pins 0 to 15 sit in bits 15-0 of the low registers, pins 16 to 31 in bits 15-0 of the high ones.
// - The data registers are not set by reset and are undefined until written or loaded.
// - Reset loads the low direction register with fc0f.
// - Reset loads the high direction register with ffff, so the upper pins are inputs.
// - Reset clears both mode registers.
// - After reset pin 1 is a pulled-down input, pins 4 to 9 run their normal function, the rest pulled-up inputs.
// - A low strap during reset puts pins 26 and 29 on their normal function.
// - Pins 1 and 6 pull down as a pulled input, the other pins pull up.
// - A direction bit of 1 makes a pin an input and 0 an output, together with its mode bit.
`timescale 1ns/1ps

module pio_port (
   input  wire logic                        clk,
   input  wire logic                        rst_b,
   // APB slave
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [pio_pkg::ADDR_W-1:0]  paddr,
   input  wire logic [31:0]                 pwdata,
   input  wire logic [3:0]                  pstrb,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   // Reset strap, low selects normal function on pins 26 and 29
   input  wire logic                        strap_bus_high_en,
   // Peripheral side of every pin
   input  wire logic [pio_pkg::PINS-1:0]    periph_out,
   input  wire logic [pio_pkg::PINS-1:0]    periph_oe,
   // Pad side of every pin
   input  wire logic [pio_pkg::PINS-1:0]    pin_in,
   output logic      [pio_pkg::PINS-1:0]    pin_out,
   output logic      [pio_pkg::PINS-1:0]    pin_oe,
   output logic      [pio_pkg::PINS-1:0]    pin_pull_en,
   output logic      [pio_pkg::PINS-1:0]    pin_pull_up
);

   // Whole state of the port
   typedef struct packed {
      logic [pio_pkg::HALF-1:0] mode_low;
      logic [pio_pkg::HALF-1:0] mode_high;
      logic [pio_pkg::HALF-1:0] dir_low;
      logic [pio_pkg::HALF-1:0] dir_high;
      logic [pio_pkg::HALF-1:0] value_low;
      logic [pio_pkg::HALF-1:0] value_high;
      logic [31:0]              rdata;
      logic                     strap_done;
   } pio_state_type;

   pio_state_type               st_r;
   pio_state_type               st_nxt;

   logic [pio_pkg::IDX_W-1:0]   idx;
   logic                        setup_phase;
   logic                        access_phase;
   logic                        hit_mode_low;
   logic                        hit_mode_high;
   logic                        hit_dir_low;
   logic                        hit_dir_high;
   logic                        hit_value_low;
   logic                        hit_value_high;
   logic                        mapped;
   logic                        wr_en;
   logic [pio_pkg::HALF-1:0]    wdata_half;
   logic [1:0]                  wstrb_half;
   logic [pio_pkg::HALF-1:0]    rd_half;
   logic [pio_pkg::PINS-1:0]    mode_all;
   logic [pio_pkg::PINS-1:0]    dir_all;
   logic [pio_pkg::PINS-1:0]    value_all;
   logic [pio_pkg::PINS-1:0]    input_all;
   logic [pio_pkg::PINS-1:0]    sampled;

   // Merge write data into a register under its two byte strobes
   function automatic logic [pio_pkg::HALF-1:0] pio_merge(
      input logic [pio_pkg::HALF-1:0] old_val,
      input logic [pio_pkg::HALF-1:0] new_val,
      input logic [1:0]               strb
   );
      logic [pio_pkg::HALF-1:0] res;
      res = old_val;
      if (strb[0]) begin
         res[7:0] = new_val[7:0];
      end
      if (strb[1]) begin
         res[15:8] = new_val[15:8];
      end
      return res;
   endfunction

   // Data bit update: inputs follow the pin, others keep or take writes
   function automatic logic [pio_pkg::HALF-1:0] pio_value_next(
      input logic [pio_pkg::HALF-1:0] old_val,
      input logic [pio_pkg::HALF-1:0] pin_lvl,
      input logic [pio_pkg::HALF-1:0] is_in,
      input logic                     wr,
      input logic [pio_pkg::HALF-1:0] new_val,
      input logic [1:0]               strb
   );
      logic [pio_pkg::HALF-1:0] res;
      res = old_val;
      if (wr) begin
         res = pio_merge(old_val, new_val, strb);
      end
      res = (res & ~is_in) | (pin_lvl & is_in);
      return res;
   endfunction

   // Address decode on the word index
   always_comb begin
      idx            = paddr[pio_pkg::IDX_LSB +: pio_pkg::IDX_W];
      setup_phase    = psel && !penable;
      access_phase   = psel && penable;
      hit_mode_low   = (idx == pio_pkg::IDX_MODE_LOW);
      hit_mode_high  = (idx == pio_pkg::IDX_MODE_HIGH);
      hit_dir_low    = (idx == pio_pkg::IDX_DIR_LOW);
      hit_dir_high   = (idx == pio_pkg::IDX_DIR_HIGH);
      hit_value_low  = (idx == pio_pkg::IDX_VALUE_LOW);
      hit_value_high = (idx == pio_pkg::IDX_VALUE_HIGH);
      mapped         = hit_mode_low || hit_mode_high || hit_dir_low
                       || hit_dir_high || hit_value_low || hit_value_high;
      wr_en          = access_phase && pwrite && mapped;
      wdata_half     = pwdata[pio_pkg::HALF-1:0];
      wstrb_half     = pstrb[1:0];
   end

   // Zero wait state slave, error on unmapped words
   always_comb begin
      pready  = 1'b1;
      pslverr = access_phase && !mapped;
      prdata  = st_r.rdata;
   end

   // Read multiplexer, pins in register order
   always_comb begin
      if (hit_mode_low) begin
         rd_half = st_r.mode_low;
      end else if (hit_mode_high) begin
         rd_half = st_r.mode_high;
      end else if (hit_dir_low) begin
         rd_half = st_r.dir_low;
      end else if (hit_dir_high) begin
         rd_half = st_r.dir_high;
      end else if (hit_value_low) begin
         rd_half = st_r.value_low;
      end else if (hit_value_high) begin
         rd_half = st_r.value_high;
      end else begin
         rd_half = pio_pkg::READ_PAD;
      end
   end

   // Per-pin vectors from the register pairs
   always_comb begin
      mode_all  = {st_r.mode_high, st_r.mode_low};
      dir_all   = {st_r.dir_high, st_r.dir_low};
      value_all = {st_r.value_high, st_r.value_low};
      sampled   = pin_in;
   end

   // One pad cell per pin
   genvar g;
   generate
      for (g = 0; g < pio_pkg::PINS; g++) begin : g_pin
         pio_pin_cell #(
            .PULL_DOWN (pio_pkg::PULL_DOWN_MASK[g])
         ) u_cell (
            .mode_bit   (mode_all[g]),
            .dir_bit    (dir_all[g]),
            .value_bit  (value_all[g]),
            .periph_out (periph_out[g]),
            .periph_oe  (periph_oe[g]),
            .pin_out    (pin_out[g]),
            .pin_oe     (pin_oe[g]),
            .pull_en    (pin_pull_en[g]),
            .pull_up    (pin_pull_up[g]),
            .gp_input   (input_all[g])
         );
      end
   endgenerate

   // Next state
   always_comb begin
      st_nxt = st_r;

      // Read data captured in the setup cycle
      if (setup_phase && !pwrite) begin
         st_nxt.rdata = {pio_pkg::READ_PAD, rd_half};
      end

      // Mode registers
      if (wr_en && hit_mode_low) begin
         st_nxt.mode_low = pio_merge(st_r.mode_low, wdata_half, wstrb_half);
      end
      if (wr_en && hit_mode_high) begin
         st_nxt.mode_high = pio_merge(st_r.mode_high, wdata_half, wstrb_half);
      end

      // Direction registers; open drain toggles these bits only
      if (wr_en && hit_dir_low) begin
         st_nxt.dir_low = pio_merge(st_r.dir_low, wdata_half, wstrb_half);
      end
      if (wr_en && hit_dir_high) begin
         st_nxt.dir_high = pio_merge(st_r.dir_high, wdata_half, wstrb_half);
      end

      // Strap taken once, in the first cycle after reset release
      if (!st_r.strap_done) begin
         st_nxt.strap_done = 1'b1;
         if (!strap_bus_high_en) begin
            st_nxt.dir_high = st_r.dir_high & ~pio_pkg::STRAP_NORMAL_HIGH;
         end
      end

      // Data registers follow inputs, hold written output values
      st_nxt.value_low  = pio_value_next(st_r.value_low,
                                         sampled[pio_pkg::HALF-1:0],
                                         input_all[pio_pkg::HALF-1:0],
                                         wr_en && hit_value_low,
                                         wdata_half, wstrb_half);
      st_nxt.value_high = pio_value_next(st_r.value_high,
                                         sampled[pio_pkg::PINS-1:pio_pkg::HALF],
                                         input_all[pio_pkg::PINS-1:pio_pkg::HALF],
                                         wr_en && hit_value_high,
                                         wdata_half, wstrb_half);
   end

   // State register; data registers deliberately left out of reset
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         st_r.mode_low   <= pio_pkg::MODE_LOW_RST;
         st_r.mode_high  <= pio_pkg::MODE_HIGH_RST;
         st_r.dir_low    <= pio_pkg::DIR_LOW_RST;
         st_r.dir_high   <= pio_pkg::DIR_HIGH_RST;
         st_r.rdata      <= 32'h0000_0000;
         st_r.strap_done <= 1'b0;
         st_r.value_low  <= st_nxt.value_low;
         st_r.value_high <= st_nxt.value_high;
      end else begin
         st_r <= st_nxt;
      end
   end

endmodule // pio_port

// File: test/pio_pad_model.sv
// Pad and board model on the far side of the I/O port
`timescale 1ns/1ps

module pio_pad_model (
   input  wire logic        clk,
   input  wire logic [31:0] pin_out,
   input  wire logic [31:0] pin_oe,
   input  wire logic [31:0] pin_pull_en,
   input  wire logic [31:0] pin_pull_up,
   input  wire logic [31:0] ext_val,
   input  wire logic [31:0] ext_oe,
   output logic      [31:0] pin_in
);
   logic [31:0] last = '0;

   // Port drive wins, then outside drive, then pull, else a floating level
   always_comb begin
      for (int i = 0; i < 32; i++) begin
         if (pin_oe[i]) pin_in[i] = pin_out[i];
         else if (ext_oe[i]) pin_in[i] = ext_val[i];
         else if (pin_pull_en[i]) pin_in[i] = pin_pull_up[i];
         else pin_in[i] = ~last[i];
      end
   end

   // Floating lines flip every cycle
   always_ff @(posedge clk) begin
      last <= pin_in;
   end
endmodule // pio_pad_model

// File: test/pio_port_sva.sv
// Port-level assertions of the programmable I/O port
`timescale 1ns/1ps

module pio_port_sva (
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic        strap_bus_high_en,
   input wire logic [31:0] periph_out,
   input wire logic [31:0] periph_oe,
   input wire logic [31:0] pin_out,
   input wire logic [31:0] pin_oe,
   input wire logic [31:0] pin_pull_en,
   input wire logic [31:0] pin_pull_up
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   // Index decode of the six registers
   logic mapped;
   assign mapped = paddr[11:2] inside {10'h070, 10'h072, 10'h074, 10'h076, 10'h078, 10'h07a};

   sequence rel_s; rst_b && !$past(rst_b); endsequence
   sequence setup_s; psel && !penable; endsequence
   sequence access_s; psel && penable; endsequence

   pull_sense_a: assert property (pin_pull_up == ~pio_pkg::PULL_DOWN_MASK) else $error("pull sense");
   pull_idle_a: assert property ((pin_pull_en & pin_oe) == 32'h0) else $error("pulled pin driven");
   reset_pull_a: assert property (rel_s |-> pin_pull_en == 32'hffff_fc0f) else $error("reset pulls");
   reset_drive_a: assert property (rel_s |-> (pin_oe & 32'hffff_fc0f) == 32'h0 && pin_oe[9:4] == periph_oe[9:4]
      && pin_out[9:4] == periph_out[9:4]) else $error("reset drive");
   strap_pins_a: assert property (rel_s |=> pin_pull_en[26] == $past(strap_bus_high_en)
      && pin_pull_en[29] == $past(strap_bus_high_en)) else $error("strap pins");
   err_phase_a: assert property (pslverr |-> psel && penable) else $error("error outside access");
   err_map_a: assert property (access_s |-> pslverr == !mapped) else $error("error decode");
   pad_zero_a: assert property (prdata[31:16] == 16'h0000) else $error("upper read lanes");
   // Only a read setup reloads the read data, so a write to a hole proves nothing here
   unmapped_zero_a: assert property (setup_s ##0 !mapped && !pwrite ##1 access_s |-> prdata == 32'h0)
      else $error("unmapped read data");
endmodule // pio_port_sva

bind pio_port pio_port_sva pio_port_sva_inst (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .prdata, .pslverr,
   .strap_bus_high_en, .periph_out, .periph_oe, .pin_out, .pin_oe, .pin_pull_en, .pin_pull_up);

// File: test/tb_top.sv
// Self-checking bench of the programmable I/O port
`timescale 1ns/1ps

module tb_top;
   logic        clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, strap = 1, pready, pslverr, er;
   logic [11:0] paddr = '0;
   logic [3:0]  pstrb = 4'hf;
   logic [31:0] pwdata = '0, prdata, pin_in, pin_out, pin_oe, pull_en, pull_up, rd;
   logic [31:0] p_out = 32'h0000_5a5a, p_oe = 32'h0000_c3c3, ext_val = '0, ext_oe = '0;
   logic [9:0]  cfg_idx [4] = '{10'h070, 10'h072, 10'h076, 10'h078};
   logic [31:0] cfg_rst [4] = '{32'h0, 32'h0000_fc0f, 32'h0, 32'h0000_ffff};
   int          err_total = 0, n_compared = 0;

   always #50 clk = ~clk;

   pio_port pio_port_inst (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .strap_bus_high_en(strap), .periph_out(p_out), .periph_oe(p_oe), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_en(pull_en), .pin_pull_up(pull_up));
   pio_pad_model pio_pad_model_inst (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_en(pull_en),
      .pin_pull_up(pull_up), .ext_val(ext_val), .ext_oe(ext_oe), .pin_in(pin_in));

   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One APB transfer, held until pready is seen
   task automatic apb(logic wr, logic [9:0] idx, logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1 && ++n < 16);
      if (n >= 16) err_total++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic do_reset(logic s);
      rst_b <= 1'b0;
      strap <= s;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
   endtask

   // Main sequence
   initial begin
      do_reset(1'b1);
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, cfg_idx[i], 32'h0);
         chk("reset cfg", cfg_rst[i], rd);
      end
      // Low half as outputs
      apb(1'b1, 10'h070, 32'h0000_ffff);
      apb(1'b1, 10'h072, 32'h0);
      apb(1'b1, 10'h074, 32'h0000_a5c3);
      @(negedge clk);
      chk("oe low", 32'h0000_ffff, {16'h0, pin_oe[15:0]});
      chk("out low", 32'h0000_a5c3, {16'h0, pin_out[15:0]});
      apb(1'b0, 10'h074, 32'h0);
      chk("value low", 32'h0000_a5c3, rd);
      // Open drain: direction carries the level
      apb(1'b1, 10'h072, 32'h0000_0004);
      @(negedge clk);
      chk("oe drain", 32'h0000_fffb, {16'h0, pin_oe[15:0]});
      // High half inputs without pull, driven outside
      ext_oe <= 32'hffff_0000;
      ext_val <= 32'h3c96_0000;
      apb(1'b1, 10'h076, 32'h0000_ffff);
      apb(1'b0, 10'h07a, 32'h0);
      chk("value high", 32'h0000_3c96, rd);
      chk("pull high", 32'h0, {16'h0, pull_en[31:16]});
      // Pulled inputs with nothing outside
      ext_oe <= 32'h0;
      apb(1'b1, 10'h076, 32'h0);
      apb(1'b1, 10'h070, 32'h0);
      apb(1'b1, 10'h072, 32'h0000_ffff);
      apb(1'b0, 10'h074, 32'h0);
      chk("pull low", 32'h0000_ffbd, rd);
      apb(1'b0, 10'h07a, 32'h0);
      chk("pull up", 32'h0000_ffff, rd);
      // Normal function follows the peripheral
      apb(1'b1, 10'h072, 32'h0);
      @(negedge clk);
      chk("normal oe", 32'h0000_c3c3, {16'h0, pin_oe[15:0]});
      chk("normal out", 32'h0000_5a5a, {16'h0, pin_out[15:0]});
      // Unmapped index
      apb(1'b0, 10'h071, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, er});
      chk("unmapped data", 32'h0, rd);
      // Strap low through reset
      do_reset(1'b0);
      apb(1'b0, 10'h078, 32'h0);
      chk("strap dir", 32'h0000_dbff, rd);
      give_verdict();
   end

   // Watchdog
   initial begin
      repeat (3000) @(posedge clk);
      err_total++;
      give_verdict();
   end
endmodule // tb_top
